// [tmtc_pkg.sv]
// package: constants, map and states of the tape motion timing control
// What this block does
// - power-up selects the slow start/stop speed.
// - two speeds: start/stop slow mode, streaming fast mode.
// - slow mode 1600 bpi holds speed 4.0 ms after read, 2.8 ms after write.
// - reinstruct during deceleration re-accelerates without full stop.
// - 6250 bpi write reinstruct in first 2.5 ms gives 0.37 in gap, else 0.43.
// - slow start or stop takes 5.0 ms, less if early; no delay after stop.
// - streaming gap end with no command starts a reposition cycle.
// - reposition stops, backs up, stops; pending command accelerates at once.
// - streaming start from reposition stop takes 10.0 ms.
// - reels coast during reposition, stop after idling, never reverse.
// - streaming write gap grows with reinstruct delay, capped at selected max.
// - gap after reposition is fixed: 0.30 in 6250, 0.60 in 1600.
// - slow mode gaps 0.37-0.43 in at 6250 bpi, 0.60 in at 1600.
// - streaming read repositions after 1.2 in of gap or on next block.
// - reads are accepted at any gap length; only writes wait for the fixed gap.
// - block-caused reposition is referenced to that block's start.
// - host picks max gap from three per density; drive honours it.
// - reposition lasts 50, 53 or 56 ms by selected gap.
// - speed change only when previous command is complete.
// - speed change takes 400 ms down, 700 ms up.
package tmtc_pkg;
  localparam int CLK_MHZ      = 40;
  localparam int HOLD_RD_US   = 4000;
  localparam int HOLD_WR_US   = 2800;
  localparam int RAMP_SS_US   = 5000;
  localparam int EARLY_US     = 2500;
  localparam int START_ST_US  = 10000;
  localparam int REPO_RAMP_US = 5000;
  localparam int REPO0_MS     = 50;
  localparam int REPO1_MS     = 53;
  localparam int REPO2_MS     = 56;
  localparam int SPD_DN_MS    = 400;
  localparam int SPD_UP_MS    = 700;
  localparam int TICK_HI_US   = 100;
  localparam int TICK_LO_US   = 200;
  localparam int REEL_IDLE_MS = 100;
  // gap lengths in hundredths of an inch
  localparam logic [7:0] GAP_SS_SHORT = 8'h25;
  localparam logic [7:0] GAP_SS_FULL  = 8'h2b;
  localparam logic [7:0] GAP_6250_FIX = 8'h1e;
  localparam logic [7:0] GAP_1600_FIX = 8'h3c;
  localparam logic [7:0] GAP_STEP     = 8'h1e;
  localparam logic [7:0] GAP_RD_MAX   = 8'h78;
  // register map
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CMD  = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_GAP  = 8'h0c;
  localparam int CTRL_DENS = 0;
  localparam int CTRL_SEL  = 1;
  localparam int CMD_GO    = 0;
  localparam int CMD_WR    = 1;
  localparam int CMD_SPD   = 8;
  localparam int CMD_TGT   = 9;
  typedef enum logic [2:0] {
    S_STOP   = 3'b000,
    S_ACCEL  = 3'b001,
    S_RECORD = 3'b010,
    S_HOLD   = 3'b011,
    S_DECEL  = 3'b100,
    S_GAPRUN = 3'b101,
    S_REPO   = 3'b110,
    S_SPEED  = 3'b111
  } tmtc_st_t;
  function automatic int us2cyc(int us);
    return us * CLK_MHZ;
  endfunction
endpackage

// [tmtc_motion.sv]
// tape motion sequencer with apb register slave
`timescale 1ns/100ps
module tmtc_motion #(
  parameter int T_HOLD_RD  = tmtc_pkg::us2cyc(tmtc_pkg::HOLD_RD_US),
  parameter int T_HOLD_WR  = tmtc_pkg::us2cyc(tmtc_pkg::HOLD_WR_US),
  parameter int T_RAMP     = tmtc_pkg::us2cyc(tmtc_pkg::RAMP_SS_US),
  parameter int T_EARLY    = tmtc_pkg::us2cyc(tmtc_pkg::EARLY_US),
  parameter int T_START_ST = tmtc_pkg::us2cyc(tmtc_pkg::START_ST_US),
  parameter int T_REPO_RMP = tmtc_pkg::us2cyc(tmtc_pkg::REPO_RAMP_US),
  parameter int T_REPO0    = tmtc_pkg::us2cyc(tmtc_pkg::REPO0_MS * 1000),
  parameter int T_REPO1    = tmtc_pkg::us2cyc(tmtc_pkg::REPO1_MS * 1000),
  parameter int T_REPO2    = tmtc_pkg::us2cyc(tmtc_pkg::REPO2_MS * 1000),
  parameter int T_SPD_DN   = tmtc_pkg::us2cyc(tmtc_pkg::SPD_DN_MS * 1000),
  parameter int T_SPD_UP   = tmtc_pkg::us2cyc(tmtc_pkg::SPD_UP_MS * 1000),
  parameter int T_TICK_HI  = tmtc_pkg::us2cyc(tmtc_pkg::TICK_HI_US),
  parameter int T_TICK_LO  = tmtc_pkg::us2cyc(tmtc_pkg::TICK_LO_US),
  parameter int T_REEL     = tmtc_pkg::us2cyc(tmtc_pkg::REEL_IDLE_MS * 1000)
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // data channel and head pins
  input  wire logic        rec_end_pin,
  input  wire logic        blk_pin,
  // drive outputs
  output logic             busy,
  output logic             speed_hi,
  output logic             cap_fwd,
  output logic             cap_rev,
  output logic             reel_run
);
  import tmtc_pkg::*;

  typedef struct packed {
    tmtc_st_t    st;
    logic [31:0] tmr;
    logic [31:0] tick;
    logic [31:0] reel;
    logic [7:0]  gap;
    logic [7:0]  gap_last;
    logic [1:0]  sel;
    logic        dens;
    logic        fast;
    logic        tgt;
    logic        pend;
    logic        pwr;
    logic        opwr;
    logic        short_nxt;
    logic        blk_ref;
    logic        busy;
    logic        cap_fwd;
    logic        cap_rev;
    logic        reel_run;
    logic [1:0]  s_end;
    logic [1:0]  s_blk;
    logic        end_d;
    logic        blk_d;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } tmtc_q_t;

  tmtc_q_t q;
  tmtc_q_t next_q;
  logic    end_e;
  logic    blk_e;
  logic    wr_en;

  function automatic logic [31:0] ld(int c);
    return 32'(c - 1);
  endfunction

  // selected maximum; code 3 is read as the largest
  function automatic logic [7:0] max_gap(logic d, logic [1:0] s);
    logic [7:0] b;
    logic [1:0] k;
    b = d ? GAP_6250_FIX : GAP_1600_FIX;
    k = (s == 2'h3) ? 2'h2 : s;
    return 8'(b + GAP_STEP * k);
  endfunction

  function automatic logic [7:0] fix_gap(logic d);
    return d ? GAP_6250_FIX : GAP_1600_FIX;
  endfunction

  assign end_e = q.s_end[1] & ~q.end_d;
  assign blk_e = q.s_blk[1] & ~q.blk_d;
  assign wr_en = psel & penable & q.pready & pwrite & ~q.pslverr;

  assign prdata   = q.prdata;
  assign pready   = q.pready;
  assign pslverr  = q.pslverr;
  assign busy     = q.busy;
  assign speed_hi = q.fast;
  assign cap_fwd  = q.cap_fwd;
  assign cap_rev  = q.cap_rev;
  assign reel_run = q.reel_run;

  always_comb begin
    logic [31:0] el;
    el = 32'(T_RAMP - 1) - q.tmr;
    next_q = q;
    next_q.s_end = {q.s_end[0], rec_end_pin};
    next_q.s_blk = {q.s_blk[0], blk_pin};
    next_q.end_d = q.s_end[1];
    next_q.blk_d = q.s_blk[1];
    next_q.tmr = (q.tmr != 32'h0) ? q.tmr - 32'h1 : 32'h0;
    next_q.tick = q.tick + 32'h1;

    // apb: answer in the access cycle after every setup
    next_q.pready = psel & ~penable;
    if (psel & ~penable) begin
      next_q.pslverr = 1'b0;
      next_q.prdata = 32'h0;
      case (paddr)
        OFF_CTRL: next_q.prdata = {29'h0, q.sel, q.dens};
        OFF_CMD:  next_q.prdata = 32'h0;
        OFF_STAT: next_q.prdata = {21'h0, q.tgt, q.opwr, q.blk_ref,
                                   q.short_nxt, q.pend, q.reel_run,
                                   q.fast, q.busy, q.st};
        OFF_GAP:  next_q.prdata = {16'h0, q.gap, q.gap_last};
        default:  next_q.pslverr = 1'b1;
      endcase
    end

    // reels coast down and stop when idle; no reverse drive exists
    if (q.st == S_STOP) begin
      next_q.reel = q.reel + 32'h1;
      if (q.reel >= ld(T_REEL)) begin
        next_q.reel = q.reel;
        next_q.reel_run = 1'b0;
      end
    end else if (q.st != S_SPEED) begin
      next_q.reel = 32'h0;
      next_q.reel_run = 1'b1;
    end

    case (q.st)
      S_STOP: begin
        next_q.cap_fwd = 1'b0;
        next_q.cap_rev = 1'b0;
        if (q.pend) begin
          // restart from stop with no added delay
          next_q.pend = 1'b0;
          next_q.opwr = q.pwr;
          next_q.busy = 1'b1;
          next_q.st = S_ACCEL;
          next_q.tmr = q.fast ? ld(T_START_ST) : ld(T_RAMP);
          if (q.fast && q.short_nxt)
            next_q.gap_last = fix_gap(q.dens);
          else if (q.fast)
            next_q.gap_last = q.gap;
          else
            next_q.gap_last = q.dens ? GAP_SS_FULL : GAP_1600_FIX;
        end
      end
      S_ACCEL: begin
        next_q.cap_fwd = 1'b1;
        next_q.cap_rev = 1'b0;
        if (q.tmr == 32'h0) begin
          next_q.st = S_RECORD;
          next_q.short_nxt = 1'b0;
          next_q.blk_ref = 1'b0;
        end
      end
      S_RECORD: begin
        next_q.cap_fwd = 1'b1;
        if (end_e) begin
          next_q.busy = 1'b0;
          next_q.gap = 8'h0;
          next_q.tick = 32'h0;
          if (q.fast)
            next_q.st = S_GAPRUN;
          else if (!q.dens) begin
            // holdover only helps at the low density
            next_q.st = S_HOLD;
            next_q.tmr = q.opwr ? ld(T_HOLD_WR) : ld(T_HOLD_RD);
          end else begin
            next_q.st = S_DECEL;
            next_q.tmr = ld(T_RAMP);
          end
        end
      end
      S_HOLD: begin
        next_q.cap_fwd = 1'b1;
        if (q.pend) begin
          // still at speed: continue straight on
          next_q.pend = 1'b0;
          next_q.opwr = q.pwr;
          next_q.busy = 1'b1;
          next_q.gap_last = GAP_1600_FIX;
          next_q.st = S_RECORD;
        end else if (q.tmr == 32'h0) begin
          next_q.st = S_DECEL;
          next_q.tmr = ld(T_RAMP);
        end
      end
      S_DECEL: begin
        next_q.cap_fwd = 1'b0;
        if (q.pend) begin
          // ramp back up from the speed reached so far
          next_q.pend = 1'b0;
          next_q.opwr = q.pwr;
          next_q.busy = 1'b1;
          next_q.st = S_ACCEL;
          next_q.tmr = el;
          if (!q.dens)
            next_q.gap_last = GAP_1600_FIX;
          else if (el < 32'(T_EARLY))
            next_q.gap_last = GAP_SS_SHORT;
          else
            next_q.gap_last = GAP_SS_FULL;
        end else if (q.tmr == 32'h0)
          next_q.st = S_STOP;
      end
      S_GAPRUN: begin
        next_q.cap_fwd = 1'b1;
        if (q.tick >= ld(q.fast ? T_TICK_HI : T_TICK_LO)) begin
          next_q.tick = 32'h0;
          if (q.gap != 8'hff)
            next_q.gap = q.gap + 8'h1;
        end
        if (q.pend && (!q.pwr || q.gap >= fix_gap(q.dens))) begin
          // write gap never below fixed length; short reads pass
          next_q.pend = 1'b0;
          next_q.opwr = q.pwr;
          next_q.busy = 1'b1;
          next_q.gap_last = q.gap;
          next_q.st = S_RECORD;
        end else if (!q.pend &&
                     ((q.opwr && q.gap >= max_gap(q.dens, q.sel)) ||
                      (!q.opwr && (q.gap >= GAP_RD_MAX || blk_e)))) begin
          next_q.st = S_REPO;
          next_q.blk_ref = ~q.opwr & blk_e;
          next_q.short_nxt = 1'b1;
          next_q.tick = 32'h0;
          case (q.sel)
            2'h0:    next_q.tmr = ld(T_REPO0);
            2'h1:    next_q.tmr = ld(T_REPO1);
            default: next_q.tmr = ld(T_REPO2);
          endcase
        end
      end
      S_REPO: begin
        // capstan: stop, back up, stop; reels only coast
        next_q.cap_fwd = 1'b0;
        next_q.cap_rev = (q.tick >= 32'(T_REPO_RMP)) &&
                         (q.tmr >= 32'(T_REPO_RMP));
        next_q.gap = 8'h0;
        if (q.tmr == 32'h0) begin
          next_q.cap_rev = 1'b0;
          if (q.pend) begin
            next_q.pend = 1'b0;
            next_q.opwr = q.pwr;
            next_q.busy = 1'b1;
            next_q.gap_last = fix_gap(q.dens);
            next_q.st = S_ACCEL;
            next_q.tmr = ld(T_START_ST);
          end else
            next_q.st = S_STOP;
        end
      end
      S_SPEED: begin
        next_q.cap_fwd = 1'b0;
        next_q.cap_rev = 1'b0;
        if (q.tmr == 32'h0) begin
          next_q.fast = q.tgt;
          next_q.busy = 1'b0;
          next_q.short_nxt = q.tgt;
          next_q.st = S_STOP;
        end
      end
      default: next_q.st = S_STOP;
    endcase

    // register writes; a command waits in pend until the sequencer
    if (wr_en && paddr == OFF_CTRL) begin
      next_q.dens = pwdata[CTRL_DENS];
      next_q.sel = pwdata[CTRL_SEL +: 2];
    end
    if (wr_en && paddr == OFF_CMD && !q.busy && !q.pend) begin
      if (pwdata[CMD_SPD]) begin
        // accepted only between commands, tape stopped or not
        if (pwdata[CMD_TGT] != q.fast &&
            q.st != S_ACCEL && q.st != S_RECORD) begin
          next_q.st = S_SPEED;
          next_q.tgt = pwdata[CMD_TGT];
          next_q.busy = 1'b1;
          next_q.tmr = pwdata[CMD_TGT] ? ld(T_SPD_UP) : ld(T_SPD_DN);
        end
      end else if (pwdata[CMD_GO] && q.st != S_SPEED) begin
        next_q.pend = 1'b1;
        next_q.pwr = pwdata[CMD_WR];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0; // fast clear: slow mode after power-up
    end else begin
      q <= next_q;
    end
  end

  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_fast_src;
    $rose(q.fast) |-> $past(q.st) == S_SPEED && $past(q.tgt);
  endproperty
  a_fast_src: assert property (p_fast_src)
    else $error("speed rose without a speed change");

  property p_hold_len;
    (q.st == S_HOLD && $past(q.st) == S_RECORD && !q.opwr)
      |-> q.tmr == ld(T_HOLD_RD);
  endproperty
  a_hold_len: assert property (p_hold_len)
    else $error("read holdover window wrong");

  property p_decel_re;
    (q.st == S_DECEL && q.pend) |=> q.st == S_ACCEL && q.busy;
  endproperty
  a_decel_re: assert property (p_decel_re)
    else $error("decel reinstruct did not accelerate");

  logic el_ok;
  assign el_ok = (32'(T_RAMP - 1) - q.tmr) < 32'(T_EARLY);
  property p_early_gap;
    (q.st == S_DECEL && q.pend && q.dens && el_ok)
      |=> q.gap_last == GAP_SS_SHORT;
  endproperty
  a_early_gap: assert property (p_early_gap)
    else $error("early write reinstruct gap wrong");

  property p_wr_repo;
    (q.st == S_GAPRUN && !q.pend && q.opwr &&
     q.gap >= max_gap(q.dens, q.sel)) |=> q.st == S_REPO;
  endproperty
  a_wr_repo: assert property (p_wr_repo)
    else $error("no reposition at gap limit");

  property p_blk_repo;
    (q.st == S_GAPRUN && !q.pend && !q.opwr && blk_e)
      |=> q.st == S_REPO && q.blk_ref;
  endproperty
  a_blk_repo: assert property (p_blk_repo)
    else $error("next block did not reposition");

  property p_st_start;
    (q.st == S_STOP && q.fast && q.pend)
      |=> q.st == S_ACCEL && q.tmr == ld(T_START_ST);
  endproperty
  a_st_start: assert property (p_st_start)
    else $error("streaming start time wrong");

  property p_fix_gap;
    (q.st == S_REPO && q.tmr == 32'h0 && q.pend)
      |=> q.gap_last == fix_gap(q.dens) ##1 q.tmr == ld(T_START_ST) - 1;
  endproperty
  a_fix_gap: assert property (p_fix_gap)
    else $error("gap after reposition not fixed");

  property p_spd_len;
    (q.st == S_SPEED && $past(q.st) != S_SPEED)
      |-> q.tmr == (q.tgt ? ld(T_SPD_UP) : ld(T_SPD_DN));
  endproperty
  a_spd_len: assert property (p_spd_len)
    else $error("speed change time wrong");

  property p_no_rev_fwd;
    !(q.cap_fwd && q.cap_rev);
  endproperty
  a_no_rev_fwd: assert property (p_no_rev_fwd)
    else $error("capstan driven both ways");
endmodule

// [tmtc_media.sv]
// data channel model: record end and block marks at the heads
`timescale 1ns/100ps
module tmtc_media #(
  parameter int REC_LEN = 100
) (
  // clock
  input  wire logic pclk,
  // drive outputs watched
  input  wire logic busy,
  input  wire logic cap_fwd,
  // bench request for a block mark
  input  wire logic blk_go,
  // head pins
  output logic      rec_end_pin,
  output logic      blk_pin
);
  int run = 0;
  int end_hold = 0;
  int blk_hold = 0;
  // pins held 4 cycles: the drive passes them through two sync flops
  always @(posedge pclk) begin
    run <= (busy && cap_fwd) ? run + 1 : 0;
    if (busy && cap_fwd && run == REC_LEN) begin
      end_hold <= 4;
    end else if (end_hold > 0) begin
      end_hold <= end_hold - 1;
    end
    if (blk_go) begin
      blk_hold <= 4;
    end else if (blk_hold > 0) begin
      blk_hold <= blk_hold - 1;
    end
  end
  assign rec_end_pin = end_hold > 0;
  assign blk_pin     = blk_hold > 0;
endmodule

// [tb.sv]
// self-checking bench for the tape motion timing control
`timescale 1ns/100ps
module tb;
  import tmtc_pkg::*;
  localparam int HR = 30;
  localparam int HW = 21;
  localparam int TS = 60;
  localparam int RR = 20;
  localparam int SD = 50;
  localparam int SU = 80;
  localparam int RP [3] = '{200, 212, 224};
  localparam int RM = 40;
  localparam int EA = 20;
  localparam int TH = 2;
  localparam int TL = 4;
  localparam int RL = 30;
  localparam int RECN = 100;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rec_end_pin;
  logic        blk_pin;
  logic        blk_go;
  logic        busy;
  logic        speed_hi;
  logic        cap_fwd;
  logic        cap_rev;
  logic        reel_run;
  logic [31:0] rdat;
  logic        rerr;
  int          miscompares;
  int          samples_checked;
  int          n;
  int          ov;

  tmtc_motion #(.T_HOLD_RD(HR), .T_HOLD_WR(HW), .T_RAMP(RM), .T_EARLY(EA),
    .T_START_ST(TS), .T_REPO_RMP(RR), .T_REPO0(RP[0]), .T_REPO1(RP[1]),
    .T_REPO2(RP[2]), .T_SPD_DN(SD), .T_SPD_UP(SU), .T_TICK_HI(TH),
    .T_TICK_LO(TL), .T_REEL(RL)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rec_end_pin(rec_end_pin), .blk_pin(blk_pin), .busy(busy),
    .speed_hi(speed_hi), .cap_fwd(cap_fwd), .cap_rev(cap_rev),
    .reel_run(reel_run));

  tmtc_media #(.REC_LEN(RECN)) media (.pclk(pclk), .busy(busy),
    .cap_fwd(cap_fwd), .blk_go(blk_go), .rec_end_pin(rec_end_pin),
    .blk_pin(blk_pin));

  always #12.5 pclk = ~pclk;

  task automatic print_verdict();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic fail_out();
    miscompares++;
    $display("unexpected at %0t: got %h expected %h", $time, 0, 1);
    print_verdict();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_in(input int got, input int lo, input int hi);
    samples_checked++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h..%h", $time, got,
               lo, hi);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) fail_out();
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic sig(input int k);
    case (k)
      0: return busy;
      default: return cap_rev;
    endcase
  endfunction

  // n returns the cycles waited
  task automatic wait_for(input int k, input logic v, input int lim);
    n = 0;
    while (sig(k) !== v) begin
      @(posedge pclk);
      n++;
      if (n > lim) fail_out();
    end
  endtask

  // polls state until it equals v (eq) or leaves v (!eq)
  task automatic poll(input logic [2:0] v, input logic eq, input int lim);
    time t0;
    t0 = $time;
    apb(1'b0, OFF_STAT, 32'h0);
    while ((rdat[2:0] === v) !== eq) begin
      if ($time - t0 > lim * 25) fail_out();
      apb(1'b0, OFF_STAT, 32'h0);
    end
    n = int'(($time - t0) / 25);
  endtask

  // one record: command, accel, record end from the media model
  task automatic go(input logic [31:0] cmd);
    apb(1'b1, OFF_CMD, cmd);
    wait_for(0, 1'b1, 10);
    wait_for(0, 1'b0, 2000);
  endtask

  task automatic run_hold(input logic [31:0] cmd, input int exp);
    go(cmd);
    poll(S_HOLD, 1'b0, 200);
    chk_in(n, exp - 6, exp + 4);
    chk(rdat[2:0], S_DECEL);
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    blk_go = 1'b0;
    miscompares = 0;
    samples_checked = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    chk(speed_hi, 1'b0);
    apb(1'b0, OFF_STAT, 32'h0);
    chk(rdat[2:0], S_STOP);
    apb(1'b1, OFF_CTRL, 32'h6);
    apb(1'b0, OFF_CTRL, 32'h0);
    chk(rdat[2:0], 3'h6);
    apb(1'b0, 8'h10, 32'h0);
    chk(rerr, 1'b1);
    $display("test registers done");
    apb(1'b1, OFF_CTRL, 32'h0);
    run_hold(32'h1, HR);
    run_hold(32'h3, HW);
    apb(1'b1, OFF_CMD, 32'h3);
    wait_for(0, 1'b1, 30);
    apb(1'b0, OFF_STAT, 32'h0);
    chk(rdat[2:0] == S_ACCEL || rdat[2:0] == S_RECORD, 1'b1);
    wait_for(0, 1'b0, 2000);
    apb(1'b1, OFF_CMD, 32'h3);
    apb(1'b0, OFF_STAT, 32'h0);
    chk(rdat[2:0], S_RECORD);
    wait_for(0, 1'b0, 2000);
    poll(S_STOP, 1'b1, 400);
    $display("test slow 1600 done");
    apb(1'b1, OFF_CTRL, 32'h1);
    go(32'h3);
    apb(1'b0, OFF_STAT, 32'h0);
    chk(rdat[2:0], S_DECEL);
    go(32'h3);
    apb(1'b0, OFF_GAP, 32'h0);
    chk(rdat[7:0], GAP_SS_SHORT);
    poll(S_STOP, 1'b1, 400);
    apb(1'b1, OFF_CMD, 32'h3);
    wait_for(0, 1'b1, 5);
    wait_for(0, 1'b0, 2000);
    apb(1'b0, OFF_GAP, 32'h0);
    chk(rdat[7:0], GAP_SS_FULL);
    poll(S_STOP, 1'b1, 400);
    $display("test slow 6250 done");
    apb(1'b1, OFF_CMD, 32'h300);
    wait_for(0, 1'b1, 10);
    wait_for(0, 1'b0, 2000);
    chk_in(n, SU - 2, SU + 2);
    chk(speed_hi, 1'b1);
    for (int s = 0; s < 3; s++) begin
      apb(1'b1, OFF_CTRL, 32'(2 * s + 1));
      go(32'h3);
      wait_for(1, 1'b1, 600);
      ov = 0;
      n = 0;
      while (cap_rev === 1'b1 && n < 400) begin
        @(posedge pclk);
        n++;
        if (cap_fwd !== 1'b0) ov++;
      end
      chk_in(n, RP[s] - 2 * RR - 2, RP[s] - 2 * RR + 2);
      chk(ov, 0);
      poll(S_STOP, 1'b1, 400);
      chk(rdat[7], 1'b1);
      repeat (60) @(posedge pclk);
      chk(reel_run, 1'b0);
    end
    apb(1'b1, OFF_CTRL, 32'h1);
    go(32'h3);
    wait_for(1, 1'b1, 600);
    apb(1'b1, OFF_CMD, 32'h3);
    wait_for(1, 1'b0, 400);
    wait_for(0, 1'b1, RR + 4);
    poll(S_ACCEL, 1'b0, 200);
    chk_in(n, TS - 6, TS + 4);
    wait_for(0, 1'b0, 2000);
    apb(1'b0, OFF_GAP, 32'h0);
    chk(rdat[7:0], GAP_6250_FIX);
    poll(S_STOP, 1'b1, 1000);
    $display("test reposition done");
    apb(1'b1, OFF_CTRL, 32'h5);
    go(32'h3);
    apb(1'b1, OFF_CMD, 32'h3);
    wait_for(0, 1'b1, 100);
    apb(1'b0, OFF_GAP, 32'h0);
    chk(rdat[7:0], GAP_6250_FIX);
    wait_for(0, 1'b0, 2000);
    repeat (100) @(posedge pclk);
    apb(1'b1, OFF_CMD, 32'h3);
    wait_for(0, 1'b1, 10);
    apb(1'b0, OFF_STAT, 32'h0);
    chk(rdat[3:0], {1'b1, S_RECORD});
    apb(1'b0, OFF_GAP, 32'h0);
    chk_in(int'(rdat[7:0]), 100 / TH - 2, 100 / TH + 6);
    wait_for(0, 1'b0, 2000);
    apb(1'b1, OFF_CMD, 32'h1);
    wait_for(0, 1'b1, 10);
    apb(1'b0, OFF_GAP, 32'h0);
    chk_in(int'(rdat[7:0]), 0, 4);
    poll(S_STOP, 1'b1, 1000);
    $display("test streaming write done");
    go(32'h1);
    repeat (10) @(posedge pclk);
    blk_go <= 1'b1;
    @(posedge pclk);
    blk_go <= 1'b0;
    wait_for(1, 1'b1, RR + 12);
    apb(1'b0, OFF_STAT, 32'h0);
    chk(rdat[8], 1'b1);
    poll(S_STOP, 1'b1, 600);
    apb(1'b1, OFF_CTRL, 32'h0);
    go(32'h1);
    wait_for(1, 1'b1, 600);
    chk_in(n, int'(GAP_RD_MAX) * TH + RR - 4,
           int'(GAP_RD_MAX) * TH + RR + 8);
    poll(S_STOP, 1'b1, 600);
    $display("test streaming read done");
    apb(1'b1, OFF_CMD, 32'h100);
    wait_for(0, 1'b1, 10);
    wait_for(0, 1'b0, 2000);
    chk_in(n, SD - 2, SD + 2);
    chk(speed_hi, 1'b0);
    $display("test speed change done");
    print_verdict();
  end
endmodule
